// [shared/misc_regs_pkg.sv]
// Constants for the miscellaneous pin and trim register bank.
// Assumes an 8-bit register port with byte addresses.
package misc_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_PULLDOWN = 8'hb8;
  localparam logic [7:0] ADDR_REV_LOW = 8'hba;
  localparam logic [7:0] ADDR_REV_HIGH = 8'hbb;
  localparam logic [7:0] ADDR_SUPPLY_TRIM = 8'hc0;
  localparam logic [7:0] ADDR_LINE_BIAS = 8'hc3;
  localparam logic [7:0] RST_PULLDOWN = 8'hff;
  localparam logic [7:0] RST_SUPPLY_TRIM = 8'h7c;
  localparam logic [4:0] RST_LINE_BIAS = 5'h10;
  localparam int PD_CHIP_SELECT = 0;
  localparam int PD_SERIAL_CLOCK = 1;
  localparam int PD_SERIAL_IN = 2;
  localparam int PD_LINE_TRANSMIT = 3;
  localparam int PD_TEST_RESET = 4;
  localparam int PD_TEST_CLOCK = 5;
  localparam int PD_TEST_MODE_SELECT = 6;
  localparam int PD_WATCHDOG_OFF = 7;
  localparam int CORE_SEL_BIT = 0;
  localparam int PERIPH_SEL_BIT = 1;
  localparam int BANDGAP_LSB = 2;
  localparam int LINE_BIAS_W = 5;
  localparam int VALID_BIT_A = 0;
  localparam int VALID_BIT_B = 4;
  // Arbitrary neutral revision value
  localparam logic [11:0] REV_CODE_DEFAULT = 12'h5a5;
  // Download sequence: idle, check validity, copy, done
  typedef enum logic [3:0] {
    LD_IDLE = 4'b0001,
    LD_CHECK = 4'b0010,
    LD_COPY = 4'b0100,
    LD_DONE = 4'b1000
  } load_state_e;
endpackage

// [src/misc_pin_and_trim_registers.sv]
// Miscellaneous pin pull-down, revision and trim register bank.
// Assumes a register port decoded elsewhere and a one-time memory source.
//
// Contract
// [RULE1] Eight input pull-downs, each enabled by its own bit, reset to one.
// [RULE2] Bit order: cs, sclk, sdi, txd, trst, tck, tms, watchdog-off; one connects.
// [RULE3] Serial inputs and line transmit enabled only in full-power state.
// [RULE4] Watchdog-off input accepted only while host reset output high.
// [RULE5] Test interface inputs enabled only while test enable high.
// [RULE6] Line transmit held low continuously trips timeout and reports error.
// [RULE7] Read-only 12-bit revision: low byte, then high nibble, zeros above.
// [RULE8] Software writes zeros to unused upper bits of those registers.
// [RULE9] Supply trim bit 0 selects core 1.2V or 1.8V, reset zero.
// [RULE10] Supply trim bit 1 selects peripheral 2.5V or 3.3V, reset zero.
// [RULE11] Bandgap trim six bits at 7..2, reset 011111.
// [RULE12] Download overwrites trims only when memory content is valid.
// [RULE13] Line bias trim five bits, reset 10000, zero smallest.
// [RULE14] Analog supply regulator can be switched off.
// [RULE15] Peripheral and core regulators can be switched off.
// [RULE16] Low-power digital regulator stays on in ultra-low-power and off.
// [RULE17] Software avoids changing core and peripheral trim bits.
// [RULE18] Download starts after every reset, checks validity, stops if invalid.
// [RULE19] Serial status bit 0 high while download active.
// [RULE20] Every register returns to default on reset before download.
`timescale 1ns/1ps
module misc_pin_and_trim_registers
  import misc_regs_pkg::*;
#(
  parameter logic [11:0] REV_CODE = REV_CODE_DEFAULT,
  parameter int TXD_TIMEOUT_CYCLES = 4096
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0] o_reg_rdata,
  // One-time memory words and user download trigger
  input wire logic i_trim_load_trigger,
  input wire logic [7:0] i_otp_valid_word,
  input wire logic [7:0] i_otp_supply_trim,
  input wire logic [4:0] i_otp_line_bias,
  // Power state and pins
  input wire logic i_full_power_state,
  input wire logic i_low_power_state,
  input wire logic i_ultra_low_power_state,
  input wire logic i_sleep_mode,
  input wire logic i_host_reset_out_n,
  input wire logic i_test_enable,
  input wire logic i_chip_select_n,
  input wire logic i_serial_clock,
  input wire logic i_serial_in,
  input wire logic i_line_transmit,
  input wire logic i_test_reset_n,
  input wire logic i_test_clock,
  input wire logic i_test_mode_select,
  input wire logic i_watchdog_off_pin,
  // Pull-down and gated inputs
  output logic [7:0] o_pulldown_en,
  output logic o_chip_select_n,
  output logic o_serial_clock,
  output logic o_serial_in,
  output logic o_line_transmit,
  output logic o_test_reset_n,
  output logic o_test_clock,
  output logic o_test_mode_select,
  output logic o_watchdog_off,
  output logic o_txd_timeout,
  // Supply control
  output logic o_core_supply_select,
  output logic o_periph_supply_select,
  output logic [5:0] o_precision_bandgap_trim,
  output logic [LINE_BIAS_W-1:0] o_line_bias_trim,
  output logic o_analog_supply_en,
  output logic o_peripheral_supply_en,
  output logic o_core_supply_en,
  output logic o_low_power_digital_supply_en,
  // Status
  output logic o_serial_status_word_load
);

  // Elaboration checks: the timeout must fit the 16-bit counter, and the fields and read-back must fit the port
  initial begin
    if (TXD_TIMEOUT_CYCLES < 1 || TXD_TIMEOUT_CYCLES > 65535) begin
      $error("TXD_TIMEOUT_CYCLES out of range");
    end
    if (LINE_BIAS_W > DATA_W) begin
      $error("LINE_BIAS_W wider than the data port");
    end
    if (BANDGAP_LSB + $bits(o_precision_bandgap_trim) != DATA_W) begin
      $error("Bandgap field does not end at the top data bit");
    end
    if (PD_WATCHDOG_OFF >= DATA_W) begin
      $error("Pull-down bit outside the data port");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] pulldown_enable_control;
  logic core_supply_select;
  logic periph_supply_select;
  logic [5:0] precision_bandgap_trim;
  logic [LINE_BIAS_W-1:0] line_bias_trim;
  load_state_e load_state;
  load_state_e next_load_state;
  logic [15:0] txd_low_count;
  logic txd_timeout;

  // Address hits for the read path; all but the two revision hits are shared with the write path
  wire hit_pulldown = (i_reg_addr == ADDR_PULLDOWN);
  wire hit_rev_low = (i_reg_addr == ADDR_REV_LOW);
  wire hit_rev_high = (i_reg_addr == ADDR_REV_HIGH);
  wire hit_supply = (i_reg_addr == ADDR_SUPPLY_TRIM);
  wire hit_bias = (i_reg_addr == ADDR_LINE_BIAS);

  // Revision registers have no write strobe, so writes there are dropped
  wire wr_pulldown = i_reg_wr && hit_pulldown;
  wire wr_supply = i_reg_wr && hit_supply;
  wire wr_bias = i_reg_wr && hit_bias;

  // Trim fields as one byte, for read-back
  wire [7:0] supply_trim =
    {precision_bandgap_trim, periph_supply_select, core_supply_select};

  // Memory content counts as valid when either marker bit is set
  wire otp_valid = i_otp_valid_word[VALID_BIT_A] | i_otp_valid_word[VALID_BIT_B];
  wire load_idle = (load_state == LD_IDLE);
  wire load_check = (load_state == LD_CHECK);
  wire load_copy = (load_state == LD_COPY);
  wire start_load = i_trim_load_trigger && load_idle;

  // One flop per pin pull-down, each resetting to its connected state
  for (genvar b = 0; b < $bits(pulldown_enable_control); b++) begin : g_pulldown
    always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
        pulldown_enable_control[b] <= RST_PULLDOWN[b]; // RULE1 RULE20
      end else if (wr_pulldown) begin
        pulldown_enable_control[b] <= i_reg_wdata[b];
      end
    end
  end

  // A download copy wins over a register write in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      core_supply_select <= RST_SUPPLY_TRIM[CORE_SEL_BIT]; // RULE9 RULE20
    end else if (load_copy) begin
      core_supply_select <= i_otp_supply_trim[CORE_SEL_BIT]; // RULE12
    end else if (wr_supply) begin
      core_supply_select <= i_reg_wdata[CORE_SEL_BIT];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      periph_supply_select <= RST_SUPPLY_TRIM[PERIPH_SEL_BIT]; // RULE10 RULE20
    end else if (load_copy) begin
      periph_supply_select <= i_otp_supply_trim[PERIPH_SEL_BIT]; // RULE12
    end else if (wr_supply) begin
      periph_supply_select <= i_reg_wdata[PERIPH_SEL_BIT];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      precision_bandgap_trim <= RST_SUPPLY_TRIM[DATA_W-1:BANDGAP_LSB]; // RULE11 RULE20
    end else if (load_copy) begin
      precision_bandgap_trim <= i_otp_supply_trim[DATA_W-1:BANDGAP_LSB]; // RULE12
    end else if (wr_supply) begin
      precision_bandgap_trim <= i_reg_wdata[DATA_W-1:BANDGAP_LSB];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      line_bias_trim <= RST_LINE_BIAS; // RULE13 RULE20
    end else if (load_copy) begin
      line_bias_trim <= i_otp_line_bias; // RULE12
    end else if (wr_bias) begin
      line_bias_trim <= i_reg_wdata[LINE_BIAS_W-1:0]; // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Download sequencer

  always_comb begin
    case (load_state)
      LD_IDLE: begin
        next_load_state = start_load ? LD_CHECK : LD_IDLE;
      end
      LD_CHECK: begin
        // An invalid memory stops the download without copying
        next_load_state = otp_valid ? LD_COPY : LD_DONE; // RULE18
      end
      LD_COPY: begin
        next_load_state = LD_DONE;
      end
      LD_DONE: begin
        next_load_state = LD_IDLE;
      end
      default: begin
        next_load_state = LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      load_state <= LD_CHECK; // RULE18
    end else begin
      load_state <= next_load_state;
    end
  end

  // Status stays high through the check and copy states
  assign o_serial_status_word_load = load_check || load_copy; // RULE19

  ////////////////////////////////////////////////////////////////////////////
  // Line transmit timeout

  // Counts only while the input is enabled and low, so a broken wire trips it
  wire txd_en = i_full_power_state;
  wire txd_low_run = txd_en && !i_line_transmit;
  wire [15:0] txd_limit = 16'(TXD_TIMEOUT_CYCLES - 1);
  wire txd_limit_hit = (txd_low_count >= txd_limit);
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !txd_low_run) begin
      txd_low_count <= 16'h0000;
      txd_timeout <= 1'b0;
    end else if (txd_limit_hit) begin
      txd_timeout <= 1'b1; // RULE6
    end else begin
      txd_low_count <= txd_low_count + 16'h0001;
    end
  end
  assign o_txd_timeout = txd_timeout;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode and outputs

  wire [7:0] rd_pulldown = pulldown_enable_control;
  wire [7:0] rd_rev_low = REV_CODE[7:0]; // RULE7
  wire [7:0] rd_rev_high = {4'h0, REV_CODE[11:8]};
  wire [7:0] rd_bias = {3'h0, line_bias_trim};
  // Unmapped addresses read as zero
  wire [7:0] rd_mux =
    ({DATA_W{hit_pulldown}} & rd_pulldown) |
    ({DATA_W{hit_rev_low}} & rd_rev_low) |
    ({DATA_W{hit_rev_high}} & rd_rev_high) |
    ({DATA_W{hit_supply}} & supply_trim) |
    ({DATA_W{hit_bias}} & rd_bias);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin pull-downs and input gating

  // A disabled input shows its idle level to the logic behind it, except test reset, which reads low
  assign o_pulldown_en = pulldown_enable_control; // RULE2
  wire serial_inputs_en = txd_en; // RULE3
  wire watchdog_input_en = i_host_reset_out_n; // RULE4
  wire test_inputs_en = i_test_enable; // RULE5

  assign o_chip_select_n = serial_inputs_en ? i_chip_select_n : 1'b1; // RULE3
  assign o_serial_clock = serial_inputs_en & i_serial_clock;
  assign o_serial_in = serial_inputs_en & i_serial_in;
  assign o_line_transmit = serial_inputs_en ? i_line_transmit : 1'b1;
  assign o_watchdog_off = watchdog_input_en & i_watchdog_off_pin; // RULE4
  assign o_test_reset_n = test_inputs_en & i_test_reset_n; // RULE5
  assign o_test_clock = test_inputs_en & i_test_clock;
  assign o_test_mode_select = test_inputs_en & i_test_mode_select;

  ////////////////////////////////////////////////////////////////////////////
  // Supply control

  assign o_core_supply_select = core_supply_select; // RULE9 RULE17
  assign o_periph_supply_select = periph_supply_select; // RULE10
  assign o_precision_bandgap_trim = precision_bandgap_trim; // RULE11
  assign o_line_bias_trim = line_bias_trim; // RULE13

  // Sleep and the deepest states switch the analog regulator off, and the peripheral and core ones unless in low-power state
  wire supplies_on = !i_sleep_mode && !i_ultra_low_power_state;
  wire regulators_on = supplies_on || i_low_power_state;
  assign o_analog_supply_en = supplies_on; // RULE14
  assign o_peripheral_supply_en = regulators_on; // RULE15
  assign o_core_supply_en = regulators_on;
  // Registers and power management live on this supply, so it never turns off
  assign o_low_power_digital_supply_en = 1'b1; // RULE16

endmodule

// [tb/misc_regs_monitor.sv]
// Port checker for the pin and trim register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module misc_regs_monitor (
  // Clock, reset and register port
  input wire logic i_ref_clk, i_rst, i_reg_rd,
  input wire logic [7:0] i_reg_addr, o_reg_rdata, i_otp_valid_word,
  // Download
  input wire logic [4:0] i_otp_line_bias, o_line_bias_trim,
  input wire logic o_serial_status_word_load,
  // Pins and supplies
  input wire logic i_full_power_state, i_chip_select_n, o_chip_select_n,
  input wire logic i_watchdog_off_pin, i_host_reset_out_n, o_watchdog_off,
  input wire logic i_test_clock, i_test_enable, o_test_clock,
  input wire logic i_line_transmit, o_txd_timeout, i_sleep_mode,
  input wire logic i_ultra_low_power_state, o_analog_supply_en,
  input wire logic o_low_power_digital_supply_en
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  cs_gate_a: assert property (o_chip_select_n == (i_full_power_state ? i_chip_select_n : 1'b1))
    else $error("chip select gate wrong");
  wd_gate_a: assert property (o_watchdog_off == (i_watchdog_off_pin & i_host_reset_out_n))
    else $error("watchdog-off gate wrong");
  test_gate_a: assert property (o_test_clock == (i_test_clock & i_test_enable))
    else $error("test clock gate wrong");
  rev_high_a: assert property (i_reg_rd && i_reg_addr == 8'hbb |=> o_reg_rdata[7:4] == 4'h0)
    else $error("revision high nibble upper bits set");
  load_start_a: assert property ($fell(i_rst) |-> o_serial_status_word_load ##[1:2] !o_serial_status_word_load)
    else $error("download status after reset wrong");
  bias_copy_a: assert property ($fell(o_serial_status_word_load) && (i_otp_valid_word[0] || i_otp_valid_word[4]) |-> o_line_bias_trim == i_otp_line_bias)
    else $error("bias trim not copied");
  txd_cause_a: assert property ($rose(o_txd_timeout) |-> !$past(i_line_transmit) && $past(i_full_power_state))
    else $error("timeout without low transmit");
  supply_on_a: assert property (o_low_power_digital_supply_en && o_analog_supply_en == !(i_sleep_mode || i_ultra_low_power_state))
    else $error("supply enable wrong");
endmodule
bind misc_pin_and_trim_registers misc_regs_monitor i_mon (.*);

// [tb/host_port_model.sv]
// Host side of the register port, issuing one access at a time.
// Assumes read data is valid one edge after the read strobe.
`timescale 1ns/1ps
module host_port_model (
  // Clock and read data
  input wire logic i_ref_clk,
  input wire logic [7:0] i_reg_rdata,
  // Register strobes
  output logic o_reg_wr = 1'b0,
  output logic o_reg_rd = 1'b0,
  output logic [7:0] o_reg_addr = 8'h00,
  output logic [7:0] o_reg_wdata = 8'h00
);
  // Callers keep unused and supply select bits as they are
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= v;
    @(posedge i_ref_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_ref_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    #1 v = i_reg_rdata;
  endtask
endmodule

// [tb/test_misc_pin_and_trim_registers.sv]
// Testbench for the pin and trim register bank.
// Assumes host_port_model drives the register port.
`timescale 1ns/1ps
module test_misc_pin_and_trim_registers import misc_regs_pkg::*;;
  logic i_ref_clk = 0, i_rst = 1, i_reg_wr, i_reg_rd, i_trim_load_trigger = 0;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_pulldown_en, d;
  logic [7:0] i_otp_valid_word = 8'h00, i_otp_supply_trim = 8'h83;
  logic [4:0] i_otp_line_bias = 5'h0a, o_line_bias_trim;
  logic i_full_power_state = 0, i_low_power_state = 0, i_ultra_low_power_state = 0;
  logic i_sleep_mode = 0, i_host_reset_out_n = 1, i_test_enable = 0, i_chip_select_n = 1;
  logic i_serial_clock = 0, i_serial_in = 0, i_line_transmit = 1, i_test_reset_n = 1;
  logic i_test_clock = 0, i_test_mode_select = 0, i_watchdog_off_pin = 0;
  logic o_chip_select_n, o_serial_clock, o_serial_in, o_line_transmit, o_test_reset_n;
  logic o_test_clock, o_test_mode_select, o_watchdog_off, o_txd_timeout;
  logic o_core_supply_select, o_periph_supply_select, o_analog_supply_en;
  logic o_peripheral_supply_en, o_core_supply_en, o_low_power_digital_supply_en;
  logic o_serial_status_word_load;
  logic [5:0] o_precision_bandgap_trim;
  int n_errors = 0, tests_run = 0;
  always #25 i_ref_clk = ~i_ref_clk;
  misc_pin_and_trim_registers #(.TXD_TIMEOUT_CYCLES(8)) i_dut (.*);
  host_port_model i_host (.i_ref_clk, .i_reg_rdata(o_reg_rdata), .o_reg_wr(i_reg_wr),
    .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
  task chk(input logic [11:0] s, input logic [11:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task t_defaults;
    repeat (3) @(posedge i_ref_clk);
    #1 chk(o_pulldown_en, 8'hff);
    i_host.rd(ADDR_SUPPLY_TRIM, d);
    chk(d, 8'h7c);
    i_host.rd(ADDR_LINE_BIAS, d);
    chk(d, 8'h10);
    $display("defaults test done");
  endtask
  task t_regs;
    i_host.wr(ADDR_PULLDOWN, 8'h5a);
    #1 chk(o_pulldown_en, 8'h5a);
    i_host.wr(ADDR_REV_LOW, 8'h00);
    i_host.rd(ADDR_REV_LOW, d);
    chk(d, REV_CODE_DEFAULT[7:0]);
    i_host.rd(ADDR_REV_HIGH, d);
    chk(d, {4'h0, REV_CODE_DEFAULT[11:8]});
    i_host.wr(ADDR_LINE_BIAS, 8'h05);
    i_host.rd(ADDR_LINE_BIAS, d);
    chk(d, 8'h05);
    i_host.wr(ADDR_SUPPLY_TRIM, 8'h00);
    #1 chk(o_precision_bandgap_trim, 6'h00);
    i_host.rd(8'hb9, d);
    chk(d, 8'h00);
    $display("register test done");
  endtask
  task t_pins;
    @(posedge i_ref_clk);
    i_chip_select_n <= 1'b0;
    i_serial_clock <= 1'b1;
    i_host_reset_out_n <= 1'b0;
    i_watchdog_off_pin <= 1'b1;
    i_test_clock <= 1'b1;
    i_sleep_mode <= 1'b1;
    i_low_power_state <= 1'b1;
    i_serial_in <= 1'b1;
    i_test_mode_select <= 1'b1;
    #1 chk({o_chip_select_n, o_serial_clock, o_watchdog_off, o_test_clock}, 4'b1000);
    chk({o_serial_in, o_line_transmit, o_test_reset_n, o_test_mode_select}, 4'b0100);
    chk({o_analog_supply_en, o_core_supply_en, o_peripheral_supply_en}, 3'b011);
    @(posedge i_ref_clk);
    i_full_power_state <= 1'b1;
    i_host_reset_out_n <= 1'b1;
    i_test_enable <= 1'b1;
    i_sleep_mode <= 1'b0;
    #1 chk({o_chip_select_n, o_serial_clock, o_watchdog_off, o_test_clock}, 4'b0111);
    chk(o_low_power_digital_supply_en, 1'b1);
    chk({o_serial_in, o_line_transmit, o_test_reset_n, o_test_mode_select}, 4'b1111);
    chk({o_analog_supply_en, o_core_supply_en, o_peripheral_supply_en}, 3'b111);
    $display("pin test done");
  endtask
  task t_timeout;
    @(posedge i_ref_clk);
    i_line_transmit <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1 chk(o_txd_timeout, 1'b0);
    repeat (8) @(posedge i_ref_clk);
    #1 chk(o_txd_timeout, 1'b1);
    @(posedge i_ref_clk);
    i_line_transmit <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_txd_timeout, 1'b0);
    $display("timeout test done");
  endtask
  task t_download;
    int k;
    @(posedge i_ref_clk);
    i_otp_valid_word <= 8'h10;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (k = 0; k < 6 && o_serial_status_word_load !== 1'b0; k++) begin
      @(posedge i_ref_clk);
      #1;
    end
    if (k == 6) begin
      n_errors++;
      finish_test;
    end
    i_host.rd(ADDR_SUPPLY_TRIM, d);
    chk(d, i_otp_supply_trim);
    chk(o_line_bias_trim, 5'h0a);
    chk(o_pulldown_en, 8'hff);
    chk({o_precision_bandgap_trim, o_periph_supply_select, o_core_supply_select}, 8'h83);
    i_host.wr(ADDR_LINE_BIAS, 8'h05);
    @(posedge i_ref_clk);
    i_trim_load_trigger <= 1'b1;
    @(posedge i_ref_clk);
    i_trim_load_trigger <= 1'b0;
    #1 chk(o_serial_status_word_load, 1'b1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_line_bias_trim, 5'h0a);
    chk(o_serial_status_word_load, 1'b0);
    $display("download test done");
  endtask
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_defaults;
    t_regs;
    t_pins;
    t_timeout;
    t_download;
    finish_test;
  end
endmodule
